// ==== design/dscs_top.sv ====
// Dual speed channel select: output source switching, temperature routing,
// main channel mapping and front-end configuration outputs.
// Assumes front-end and temperature results arrive on clk as one-cycle
// strobes; the register port master follows the plain strobe protocol.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module dscs_top #(
  parameter int DATA_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic                    fast_valid,
  input  wire logic [DATA_W-1:0]       fast_data,
  input  wire logic                    precise_valid,
  input  wire logic [DATA_W-1:0]       precise_data,
  input  wire logic                    temp_valid,
  input  wire logic [1:0]              temp_sensor,
  input  wire logic [DATA_W-1:0]       temp_data,
  output logic                         conv_ready,
  output logic                         out_valid,
  output logic      [DATA_W-1:0]       out_data,
  output logic                         out_from_fast,
  input  wire logic                    out_ready,
  output logic                         excitation_en,
  output logic                         fast_conv_sel,
  output logic      [1:0]              bridge_mode,
  output logic      [3:0]              temp_acq_en,
  output logic      [3:0]              temp_acq_pair,
  output logic      [DATA_W-1:0]       main_channel_one,
  output logic      [DATA_W-1:0]       main_channel_two,
  output logic      [DATA_W-1:0]       main_channel_derived,
  output logic      [2:0][DATA_W-1:0]  logical_temp_channels
);

  if (DATA_W < 8 || DATA_W > 24) begin : g_chk
    $error("dscs_top: DATA_W must lie between 8 and 24");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Percent of full scale as a count; one bit wider so 100% fits
  function automatic logic [DATA_W:0] pct_to_cnt(input logic [6:0] pct);
    logic [DATA_W+6:0] t;
    t = {pct, {DATA_W{1'b0}}} / (DATA_W+7)'(dscs_pkg::PCT_FULL);
    return t[DATA_W:0];
  endfunction

  function automatic logic [DATA_W:0] abs_diff(input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b);
    return (a > b) ? {1'b0, a - b} : {1'b0, b - a};
  endfunction

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [2:0]              mode;
  logic [1:0]              br_mode;
  logic [6:0]              jump_pct;
  logic [6:0]              settle_pct;
  logic [3:0]              temp_en;
  logic [3:0]              temp_pair;
  logic [2:0][1:0]         tmap;
  logic [2:0][1:0]         next_tmap;
  logic [DATA_W-1:0]       last_fast;
  logic                    fast_seen;
  dscs_pkg::dscs_src_type  src;
  dscs_pkg::dscs_src_type  next_src;

  wire wr_ctrl = reg_wr & (reg_addr == dscs_pkg::ADDR_CTRL);
  wire wr_thr  = reg_wr & (reg_addr == dscs_pkg::ADDR_THR);
  wire wr_temp = reg_wr & (reg_addr == dscs_pkg::ADDR_TEMP);
  wire wr_map  = reg_wr & (reg_addr == dscs_pkg::ADDR_MAP);

  wire [2:0] wr_mode = reg_wdata[dscs_pkg::CTRL_MODE_LSB +: 3];
  wire       mode_ok = wr_mode <= dscs_pkg::DSCS_DUAL_SPEED;

  wire dual    = mode == dscs_pkg::DSCS_DUAL_SPEED;
  wire fast_on = mode != dscs_pkg::DSCS_PREC_ONLY;
  wire prec_on = mode != dscs_pkg::DSCS_FAST_ONLY;

  // Sensors are usable only behind an active front end
  wire [3:0] eff_en = temp_en & {{2{prec_on & ~dual}}, {2{fast_on}}};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode       <= dscs_pkg::MODE_RST;
      br_mode    <= dscs_pkg::BR_RST;
      jump_pct   <= dscs_pkg::JUMP_PCT_RST;
      settle_pct <= dscs_pkg::SETTLE_PCT_RST;
      temp_en    <= dscs_pkg::TEMP_EN_RST;
      temp_pair  <= dscs_pkg::TEMP_PAIR_RST;
    end else begin
      if (wr_ctrl) begin
        mode    <= mode_ok ? wr_mode : mode;
        br_mode <= reg_wdata[dscs_pkg::CTRL_BR_LSB +: 2];
      end
      if (wr_thr) begin
        jump_pct   <= reg_wdata[dscs_pkg::THR_JUMP_LSB +: 7];
        settle_pct <= reg_wdata[dscs_pkg::THR_SETTLE_LSB +: 7];
      end
      if (wr_temp) begin
        temp_en   <= reg_wdata[dscs_pkg::TEMP_EN_LSB +: 4];
        temp_pair <= reg_wdata[dscs_pkg::TEMP_PAIR_LSB +: 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature channel mapping
  // ----------------------------------------------------------------
  // A write to a disabled sensor is dropped; a map that lost its sensor
  // falls back to the default, even a disabled one; results of a disabled sensor are never taken.
  for (genvar k = 0; k < 3; k++) begin : g_map
    wire [1:0] wr_sel = reg_wdata[2*k +: 2];
    wire [1:0] dflt   = dscs_pkg::MAP_RST[2*k +: 2];
    assign next_tmap[k] = (wr_map && eff_en[wr_sel]) ? wr_sel :
                          (!eff_en[tmap[k]])         ? dflt   :
                                                       tmap[k];
  end

  wire temp_take = temp_valid & eff_en[temp_sensor];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tmap <= dscs_pkg::MAP_RST;
    end else begin
      tmap <= next_tmap;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      logical_temp_channels <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (temp_take && tmap[k] == temp_sensor) begin
          logical_temp_channels[k] <= temp_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output source selection
  // ----------------------------------------------------------------
  wire [DATA_W:0] jump_cnt   = pct_to_cnt(jump_pct);
  wire [DATA_W:0] settle_cnt = pct_to_cnt(settle_pct);
  wire [DATA_W:0] delta      = abs_diff(fast_data, last_fast);

  // Conversions are taken only while the buffer can hold them
  wire fast_take = fast_valid & conv_ready & fast_on;
  wire prec_take = precise_valid & conv_ready & prec_on;
  wire big_jump  = fast_take & fast_seen & (delta > jump_cnt);
  wire big_move  = fast_take & fast_seen & (delta > settle_cnt);

  // In dual speed mode every transition rides on a result strobe, so the source never changes
  // in the middle of a conversion; leaving that mode forces precise at once.
  always_comb begin
    next_src = src;
    case (src)
      dscs_pkg::DSCS_SRC_PRECISE: begin
        if (big_jump) begin
          next_src = dscs_pkg::DSCS_SRC_FAST;
        end
      end
      dscs_pkg::DSCS_SRC_FAST: begin
        if (!big_move && prec_take) begin
          next_src = dscs_pkg::DSCS_SRC_SETTLE;
        end
      end
      dscs_pkg::DSCS_SRC_SETTLE: begin
        if (big_move) begin
          next_src = dscs_pkg::DSCS_SRC_FAST;
        end else if (prec_take) begin
          next_src = dscs_pkg::DSCS_SRC_PRECISE;
        end
      end
      default: begin
        next_src = dscs_pkg::DSCS_SRC_PRECISE;
      end
    endcase
    if (!dual) begin
      next_src = dscs_pkg::DSCS_SRC_PRECISE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src       <= dscs_pkg::DSCS_SRC_PRECISE;
      fast_seen <= 1'b0;
      last_fast <= '0;
    end else begin
      src <= next_src;
      if (fast_take) begin
        fast_seen <= 1'b1;
        last_fast <= fast_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Merged output stream
  // ----------------------------------------------------------------
  wire use_fast  = dual ? (next_src != dscs_pkg::DSCS_SRC_PRECISE) : fast_on;
  wire push_fast = fast_take & use_fast;
  wire push_prec = prec_take & ~use_fast;
  wire push      = push_fast | push_prec;
  wire [DATA_W-1:0] push_word = push_fast ? fast_data : precise_data;

  dscs_strm_if #(.W(DATA_W+1)) buf_in ();
  dscs_strm_if #(.W(DATA_W+1)) buf_out ();

  assign buf_in.valid  = push;
  assign buf_in.data   = {push_fast, push_word};
  assign buf_out.ready = out_ready;

  dscs_pair_buf #(.W(DATA_W+1)) u_buf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .inp     (buf_in.snk),
    .outp    (buf_out.src)
  );

  assign conv_ready    = buf_in.ready;
  assign out_valid     = buf_out.valid;
  assign out_data      = buf_out.data[DATA_W-1:0];
  assign out_from_fast = buf_out.data[DATA_W];

  // ----------------------------------------------------------------
  // Main channels and front-end controls
  // ----------------------------------------------------------------
  // Channel two exists only when both ends convert separate bridges
  wire ch2_take = prec_take & fast_on & ~dual;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_channel_one     <= '0;
      main_channel_two     <= '0;
      main_channel_derived <= '0;
      excitation_en        <= 1'b0;
      fast_conv_sel        <= 1'b0;
      bridge_mode          <= dscs_pkg::BR_RST;
      temp_acq_en          <= 4'h0;
      temp_acq_pair        <= 4'h0;
    end else begin
      if (push) begin
        main_channel_one <= push_word;
      end
      if (ch2_take) begin
        main_channel_two <= precise_data;
      end
      main_channel_derived <= main_channel_one - main_channel_two;
      // Excitation follows the mode only, never the selected source
      excitation_en <= prec_on;
      fast_conv_sel <= dual;
      bridge_mode   <= br_mode;
      temp_acq_en   <= eff_en;
      temp_acq_pair <= temp_pair & eff_en;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  wire [31:0] rd_word =
    (reg_addr == dscs_pkg::ADDR_CTRL)   ? {26'h0, br_mode, 1'b0, mode} :
    (reg_addr == dscs_pkg::ADDR_THR)    ? {17'h0, settle_pct, 1'b0, jump_pct} :
    (reg_addr == dscs_pkg::ADDR_TEMP)   ? {24'h0, temp_pair, temp_en} :
    (reg_addr == dscs_pkg::ADDR_MAP)    ? {26'h0, tmap} :
    (reg_addr == dscs_pkg::ADDR_STATUS) ? {19'h0, conv_ready, src, eff_en, tmap} :
                                          32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_quiet_prec;
    prec_take && !big_move;
  endsequence

  property p_one_source;
    !(push_fast && push_prec);
  endproperty
  a_one_source: assert property (p_one_source) else $error("both ends pushed at once");
  // Sampled reset keeps the release edge, whose flops still hold reset values, out of the check
  property p_exc_steady;
    !sys_rst && dual |=> excitation_en;
  endproperty
  a_exc_steady: assert property (p_exc_steady) else $error("excitation dropped");
  property p_jump;
    dual && src == dscs_pkg::DSCS_SRC_PRECISE && big_jump
      |=> src == dscs_pkg::DSCS_SRC_FAST && out_valid;
  endproperty
  a_jump: assert property (p_jump) else $error("jump did not select fast source");
  property p_settle_back;
    dual && src == dscs_pkg::DSCS_SRC_FAST ##0 s_quiet_prec
      ##[1:300] (dual && src == dscs_pkg::DSCS_SRC_SETTLE) ##0 s_quiet_prec
      |=> src == dscs_pkg::DSCS_SRC_PRECISE;
  endproperty
  a_settle_back: assert property (p_settle_back) else $error("no return to precise");
  property p_thr_reset;
    $fell(sys_rst) |-> jump_pct == 7'h0a && settle_pct == 7'h02;
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("threshold reset values wrong");
  property p_temp_route;
    temp_take && tmap[1] == temp_sensor
      |=> logical_temp_channels[1] == $past(temp_data);
  endproperty
  a_temp_route: assert property (p_temp_route) else $error("temperature result not routed");
  property p_dual_temp;
    !sys_rst && dual |=> temp_acq_en[3:2] == 2'b00;
  endproperty
  a_dual_temp: assert property (p_dual_temp) else $error("precise sensor on in dual mode");
  property p_pair_sub;
    (temp_acq_pair & ~temp_acq_en) == 4'h0;
  endproperty
  a_pair_sub: assert property (p_pair_sub) else $error("pair scheme on inactive sensor");
  property p_ch1;
    push |=> main_channel_one == $past(push_word) ##1
      main_channel_derived == $past(main_channel_one - main_channel_two);
  endproperty
  a_ch1: assert property (p_ch1) else $error("main channel one or derived stale");
  property p_hold_src;
    src != dscs_pkg::DSCS_SRC_PRECISE && dual && !fast_take && !prec_take
      |=> $stable(src);
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("source moved between conversions");
  property p_map_revert;
    !eff_en[tmap[0]] && !wr_map
      |=> tmap[0] == dscs_pkg::MAP_RST[1:0];
  endproperty
  a_map_revert: assert property (p_map_revert) else $error("invalid channel map kept");
  property p_fast_conv;
    !sys_rst && dual |=> fast_conv_sel;
  endproperty
  a_fast_conv: assert property (p_fast_conv) else $error("fast conversion not set");

endmodule

// ==== design/dscs_pkg.sv ====
// Constants and types of the dual speed channel select block.
// Assumes a single 250 MHz clock domain and a synchronous active-high reset.
package dscs_pkg;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DSCS_FAST_ONLY   = 3'h0,
    DSCS_PREC_ONLY   = 3'h1,
    DSCS_BOTH_INDEP  = 3'h2,
    DSCS_BOTH_EQUAL  = 3'h3,
    DSCS_DUAL_SPEED  = 3'h4
  } dscs_afe_mode_type;

  typedef enum logic [1:0] {
    DSCS_BR_VOLTAGE    = 2'h0,
    DSCS_BR_RESISTOR   = 2'h1,
    DSCS_BR_CURRENT    = 2'h2,
    DSCS_BR_THERMOPILE = 2'h3
  } dscs_bridge_type;

  // Path: precise -> fast -> settle -> precise; settle -> precise flips both bits
  typedef enum logic [1:0] {
    DSCS_SRC_PRECISE = 2'b00,
    DSCS_SRC_FAST    = 2'b01,
    DSCS_SRC_SETTLE  = 2'b11
  } dscs_src_type;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_THR    = 8'h04;
  localparam logic [7:0] ADDR_TEMP   = 8'h08;
  localparam logic [7:0] ADDR_MAP    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_BR_LSB     = 4;
  localparam int THR_JUMP_LSB    = 0;
  localparam int THR_SETTLE_LSB  = 8;
  localparam int TEMP_EN_LSB     = 0;
  localparam int TEMP_PAIR_LSB   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_RST       = 3'h4;
  localparam logic [1:0] BR_RST         = 2'h0;
  localparam logic [6:0] JUMP_PCT_RST   = 7'h0a;
  localparam logic [6:0] SETTLE_PCT_RST = 7'h02;
  localparam logic [3:0] TEMP_EN_RST    = 4'h1;
  localparam logic [3:0] TEMP_PAIR_RST  = 4'hf;
  localparam logic [5:0] MAP_RST        = 6'h24;
  localparam int         PCT_FULL       = 100;

endpackage

// ==== design/dscs_strm_if.sv ====
// Valid/ready word stream between the select logic and its output buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface dscs_strm_if #(
  parameter int W = 17
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== design/dscs_pair_buf.sv ====
// Two-entry stream buffer; head word, valid and ready all come from flops.
// Assumes the source holds nothing back: it only offers while ready is high.
`timescale 1ns/100ps
module dscs_pair_buf #(
  parameter int W = 17
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  dscs_strm_if.snk   inp,
  dscs_strm_if.src   outp
);
  logic [1:0]   cnt;
  logic [W-1:0] head;
  logic [W-1:0] spare;
  logic         vld;
  logic         rdy;
  wire          push = inp.valid & rdy;
  wire          pop  = vld & outp.ready;
  wire  [1:0]   next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  if (W != $bits(inp.data)) begin : g_chk
    $error("dscs_pair_buf: W does not match the stream width");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 2'h0;
      vld <= 1'b0;
      rdy <= 1'b0;
    end else begin
      cnt <= next_cnt;
      vld <= next_cnt != 2'h0;
      rdy <= next_cnt != 2'h2;
    end
  end

  // Data flops need no reset; valid guards them
  always_ff @(posedge clk) begin
    if (pop) begin
      head  <= (cnt == 2'h2) ? spare : inp.data;
      spare <= inp.data;
    end else if (push) begin
      if (cnt == 2'h0) begin
        head <= inp.data;
      end else begin
        spare <= inp.data;
      end
    end
  end

  assign inp.ready  = rdy;
  assign outp.valid = vld;
  assign outp.data  = head;
endmodule

// ==== verif/dscs_sensor_model.sv ====
// Sensor side model: bridge results of both front ends and temperature results.
// Assumes one clock with the select block; the bench calls send to make one result.
`timescale 1ns/100ps
module dscs_sensor_model (
  input  wire logic        clk,
  output logic             fast_valid,
  output logic      [15:0] fast_data,
  output logic             precise_valid,
  output logic      [15:0] precise_data,
  output logic             temp_valid,
  output logic      [1:0]  temp_sensor,
  output logic      [15:0] temp_data
);
  initial begin
    fast_valid = 1'b0;
    precise_valid = 1'b0;
    temp_valid = 1'b0;
    fast_data = 16'h0000;
    precise_data = 16'h0000;
    temp_data = 16'h0000;
    temp_sensor = 2'h0;
  end

  // ------------------------------------------------------------
  // One result: kind 0 fast, 1 precise, 2 temperature
  // ------------------------------------------------------------
  task automatic send(input logic [1:0] kind, input logic [1:0] sensor,
                      input logic [15:0] v);
    @(posedge clk);
    case (kind)
      2'h0: begin
        fast_valid <= 1'b1;
        fast_data <= v;
      end
      2'h1: begin
        precise_valid <= 1'b1;
        precise_data <= v;
      end
      default: begin
        temp_valid <= 1'b1;
        temp_sensor <= sensor;
        temp_data <= v;
      end
    endcase
    @(posedge clk);
    fast_valid <= 1'b0;
    precise_valid <= 1'b0;
    temp_valid <= 1'b0;
    // Data flip after the strobe so a stale word is never read as fresh
    fast_data <= ~fast_data;
    precise_data <= ~precise_data;
    temp_data <= ~temp_data;
  endtask
endmodule

// ==== verif/tb_dual_speed_channel_select.sv ====
// Self-checking bench of the dual speed channel select block.
// Assumes the design files are compiled first; the sensor model sits on the result side.
`timescale 1ns/100ps
module tb_dual_speed_channel_select;
  typedef struct packed {logic [7:0] a; logic [31:0] d;} dscs_row_type;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic out_ready = 1'b1;
  logic [31:0] reg_rdata;
  logic fast_valid, precise_valid, temp_valid, conv_ready, out_valid, out_from_fast;
  logic [15:0] fast_data, precise_data, temp_data, out_data;
  logic [15:0] main_channel_one, main_channel_two, main_channel_derived;
  logic [1:0] temp_sensor, bridge_mode;
  logic excitation_en, fast_conv_sel;
  logic [3:0] temp_acq_en, temp_acq_pair;
  logic [2:0][15:0] logical_temp_channels;
  logic [16:0] got_q[$];
  int fails = 0;
  int check_count = 0;
  int n;
  dscs_row_type rows [6] = '{{8'h00, 32'h4}, {8'h04, 32'h20a}, {8'h08, 32'hf1},
                             {8'h0c, 32'h24}, {8'h10, 32'h1064}, {8'h14, 32'h0}};

  always #2 clk = ~clk;

  dscs_top DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_valid(fast_valid),
    .fast_data(fast_data), .precise_valid(precise_valid), .precise_data(precise_data),
    .temp_valid(temp_valid), .temp_sensor(temp_sensor), .temp_data(temp_data),
    .conv_ready(conv_ready), .out_valid(out_valid), .out_data(out_data),
    .out_from_fast(out_from_fast), .out_ready(out_ready), .excitation_en(excitation_en),
    .fast_conv_sel(fast_conv_sel), .bridge_mode(bridge_mode), .temp_acq_en(temp_acq_en),
    .temp_acq_pair(temp_acq_pair), .main_channel_one(main_channel_one),
    .main_channel_two(main_channel_two), .main_channel_derived(main_channel_derived),
    .logical_temp_channels(logical_temp_channels));

  dscs_sensor_model sm (.clk(clk), .fast_valid(fast_valid), .fast_data(fast_data),
    .precise_valid(precise_valid), .precise_data(precise_data), .temp_valid(temp_valid),
    .temp_sensor(temp_sensor), .temp_data(temp_data));

  always @(posedge clk) if (out_valid === 1'b1 && out_ready === 1'b1)
    got_q.push_back({out_from_fast, out_data});

  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_val(reg_rdata & mask, exp, $sformatf("reg %h", a));
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #20000;
    fails++;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    step(2);
    chk_val(excitation_en, 1'b1, "excitation");
    chk_val(fast_conv_sel, 1'b1, "conv speed");
    chk_val(temp_acq_pair, 4'h1, "pair");
    foreach (rows[i]) chk_reg(rows[i].a, 32'hffffffff, rows[i].d);
    $display("test reset done");
    // Dual speed switching, settle restart
    sm.send(2'h1, 2'h0, 16'h1000);
    sm.send(2'h0, 2'h0, 16'h1000);
    sm.send(2'h0, 2'h0, 16'h4000);
    chk_reg(8'h10, 32'hc00, 32'h400);
    sm.send(2'h0, 2'h0, 16'h4100);
    sm.send(2'h1, 2'h0, 16'h4020);
    sm.send(2'h1, 2'h0, 16'h4030);
    chk_reg(8'h10, 32'hc00, 32'h0);
    sm.send(2'h0, 2'h0, 16'h8000);
    sm.send(2'h1, 2'h0, 16'h8010);
    sm.send(2'h0, 2'h0, 16'h8800);
    sm.send(2'h1, 2'h0, 16'h8020);
    chk_reg(8'h10, 32'h400, 32'h400);
    sm.send(2'h1, 2'h0, 16'h8030);
    chk_reg(8'h10, 32'hc00, 32'h0);
    sm.send(2'h1, 2'h0, 16'h9000);
    step(3);
    chk_val(got_q[0], 17'h01000, "word 0");
    chk_val(got_q[1], 17'h14000, "word 1");
    chk_val(got_q[2], 17'h14100, "word 2");
    chk_val(got_q[$], 17'h09000, "last word");
    chk_val(main_channel_one, 16'h9000, "main one");
    chk_val(main_channel_derived, 16'h9000, "derived");
    $display("test switching done");
    // Receiver stall: two words kept, third refused
    n = got_q.size();
    @(posedge clk);
    out_ready <= 1'b0;
    sm.send(2'h1, 2'h0, 16'h5100);
    sm.send(2'h1, 2'h0, 16'h5200);
    sm.send(2'h1, 2'h0, 16'h5300);
    chk_reg(8'h10, 32'h1000, 32'h0);
    chk_val({out_valid, out_data}, 17'h15100, "stalled head");
    chk_val(conv_ready, 1'b0, "stall ready");
    @(posedge clk);
    out_ready <= 1'b1;
    step(6);
    chk_val(got_q.size(), n + 2, "drain count");
    chk_val(got_q[n+1], 17'h05200, "drain word");
    $display("test stall done");
    // Configuration and temperature routing
    for (int b = 0; b < 4; b++) begin
      wr(8'h00, 32'h4 | (b << 4));
      step(2);
      chk_val(bridge_mode, b[1:0], "bridge");
    end
    wr(8'h00, 32'h7);
    chk_reg(8'h00, 32'h7, 32'h4);
    wr(8'h04, 32'h0514);
    chk_reg(8'h04, 32'hffffffff, 32'h0514);
    wr(8'h08, 32'h5f);
    step(2);
    chk_val(temp_acq_pair, 4'h1, "pair");
    chk_val(temp_acq_en, 4'h3, "dual enables");
    wr(8'h0c, 32'h3d);
    chk_reg(8'h0c, 32'h3f, 32'h25);
    wr(8'h0c, 32'h05);
    chk_reg(8'h0c, 32'h3f, 32'h05);
    sm.send(2'h2, 2'h1, 16'h1234);
    sm.send(2'h2, 2'h0, 16'h0777);
    step(2);
    chk_val(logical_temp_channels, 48'h077712341234, "temp channels");
    wr(8'h00, 32'h1);
    step(3);
    chk_val(temp_acq_en, 4'hc, "precise enables");
    chk_val({excitation_en, fast_conv_sel}, 2'b10, "precise mode");
    chk_reg(8'h0c, 32'h3f, 32'h24);
    wr(8'h00, 32'h3);
    sm.send(2'h0, 2'h0, 16'h0300);
    sm.send(2'h1, 2'h0, 16'h0100);
    step(3);
    chk_val(main_channel_two, 16'h0100, "main two");
    chk_val(main_channel_derived, 16'h0200, "derived");
    wr(8'h00, 32'h0);
    step(2);
    chk_val(excitation_en, 1'b0, "fast only");
    $display("test config done");
    wrap_up;
  end
endmodule
